// file: dtc_cfg.svh
// Purpose: constants for the cascadable dual timer
// Assumes: AXI4-Lite data 32 bits, byte addresses below
// Notes:   one definition of each figure, shared by every file except the package
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// register byte offsets
`define DTC_OFF_CTRL_X 8'h00
`define DTC_OFF_CTRL_Y 8'h04
`define DTC_OFF_PER_X 8'h08
`define DTC_OFF_PER_Y 8'h0C
`define DTC_OFF_CNT_X 8'h10
`define DTC_OFF_CNT_Y 8'h14
`define DTC_OFF_STATUS 8'h18
`define DTC_OFF_MASK 8'h1C

// control field positions
`define DTC_BIT_RUN 15
`define DTC_BIT_HALT_IDLE 13
`define DTC_BIT_EXT_HI 9
`define DTC_BIT_EXT_LO 8
`define DTC_BIT_GATE 6
`define DTC_BIT_PRE_HI 5
`define DTC_BIT_PRE_LO 4
`define DTC_BIT_CASCADE 3
`define DTC_BIT_CLK_SEL 1

// implemented control bits; all others read as zero
`define DTC_CTRL_X_MASK 16'hA37A
`define DTC_CTRL_Y_MASK 16'hA372

// reset values
`define DTC_CTRL_RESET 16'h0000
`define DTC_PER_RESET 16'hFFFF
`define DTC_CNT_RESET 16'h0000

// extended source codes
`define DTC_EXT_GENERIC 2'h3
`define DTC_EXT_LOW_POWER_RC_OSCILLATOR 2'h2
`define DTC_EXT_PAIRED 2'h1
`define DTC_EXT_SECONDARY_OSCILLATOR 2'h0

// prescaler terminal counts for 1, 8, 64 and 256
`define DTC_PRE_LIM_1 8'h00
`define DTC_PRE_LIM_8 8'h07
`define DTC_PRE_LIM_64 8'h3F
`define DTC_PRE_LIM_256 8'hFF

// status bit positions
`define DTC_ST_X 0
`define DTC_ST_Y 1

// axi responses
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// file: dtc_pkg.sv
// Purpose: types for the cascadable dual timer
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in dtc_cfg.svh
package dtc_pkg;
    typedef enum logic {DTC_WR_IDLE, DTC_WR_RESP} dtc_wr_state_t;
    typedef enum logic {DTC_RD_IDLE, DTC_RD_VALID} dtc_rd_state_t;
endpackage

// file: dtc_prescaler.sv
// Purpose: input clock prescaler, divide by 1, 8, 64 or 256
// Assumes: in_tick is a one-cycle pulse per source edge
// Notes:   clear has priority over counting
`include "dtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dtc_prescaler (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_tick,
    input wire logic [1:0] div_sel,
    output logic out_tick,
    output logic [7:0] count
);
    logic [7:0] count_reg;
    logic [7:0] limit;

    // terminal count from the divide select
    always_comb
    begin
        case (div_sel)
            2'h0: limit = `DTC_PRE_LIM_1;
            2'h1: limit = `DTC_PRE_LIM_8;
            2'h2: limit = `DTC_PRE_LIM_64;
            default: limit = `DTC_PRE_LIM_256;
        endcase
    end

    assign out_tick = in_tick && (count_reg >= limit);
    assign count = count_reg;

    // >= rather than == so a smaller divide taken mid-count still wraps
    always_ff @(posedge ref_clk)
    begin
        if (rst || clear)
            count_reg <= 8'h00;
        else if (out_tick)
            count_reg <= 8'h00;
        else if (in_tick)
            count_reg <= count_reg + 8'h01;
    end
endmodule
`default_nettype wire

// file: dtc_top.sv
// Purpose: two 16-bit timers, joinable into one 32-bit timer, AXI4-Lite
// Assumes: idle_mode comes from logic on ref_clk; source pins are async
// Notes:   internal half-rate clock is taken as one count per ref_clk
//
// Function
// [R1] first run bit starts/stops 32-bit timer if cascaded, else first timer
// [R2] second run bit starts/stops second timer when not cascaded
// [R3] halt-in-idle set stops the timer while idle_mode is high
// [R4] extended field: 11 generic, 10 rc osc, 01 paired, 00 secondary osc
// [R5] clock select clear ignores extended field, uses internal clock
// [R6] first timer with clock select set uses the extended-field source
// [R7] second timer alone with clock select set counts paired input edges
// [R8] gated accumulation works only on internal clock, else ignored
// [R9] prescale codes 00..11 divide by 1, 8, 64, 256
// [R10] cascade bit joins both timers; clear keeps two 16-bit timers
// [R11] while cascaded the second control register has no effect
// [R12] writing a running timer's control register resets its prescaler
// [R13] unimplemented control bits read zero; control resets to zero
// [R14] cascaded: first timer low half, second timer high half
// [R15] cascaded period match sets the second timer's flag
// [R16] converter trigger only from cascaded timer or second timer alone
// [R17] timer counts per prescaled tick, wraps to zero on period match
// [R18] cascaded high half counts on low wrap; compare uses both periods
`include "dtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_mode,
    input wire logic generic_external_input,
    input wire logic paired_external_input,
    input wire logic low_power_rc_oscillator,
    input wire logic secondary_oscillator,
    output logic irq,
    output logic adc_trigger
);
    logic [15:0] ctrl_x_reg, ctrl_y_reg, per_x_reg, per_y_reg;
    logic [15:0] cnt_x_reg, cnt_y_reg;
    logic [1:0] status_reg, mask_reg, status_next, mask_next;
    logic irq_reg, adc_reg;
    logic [3:0] pin_s1_reg, pin_s2_reg, pin_d_reg, pin_rise;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic aw_have_reg, w_have_reg, awready_reg, wready_reg;
    logic bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    dtc_pkg::dtc_wr_state_t wr_state_reg;
    dtc_pkg::dtc_rd_state_t rd_state_reg;
    logic aw_fire, w_fire, ar_fire, wr_do, wr_hit;
    logic wr_ctrl_x, wr_ctrl_y, rd_status;
    logic cascade, run_x_en, run_y_en, ext_rise, src_x, src_y;
    logic tick_x, tick_y, pre_clr_x, pre_clr_y;
    logic [7:0] pre_cnt_x, pre_cnt_y;
    logic match_x, match_y, match_32;
    logic [31:0] rd_mux;

    // merge a 16-bit register with the low two byte lanes
    function automatic logic [15:0] lane16(input logic [15:0] old_v,
                                           input logic [31:0] d,
                                           input logic [3:0] s);
        lane16 = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
    endfunction

    // two-flop synchronisers, then a third stage for edge detection
    // pin order: 0 generic, 1 paired, 2 rc osc, 3 secondary osc
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pin_d_reg <= 4'h0;
        end
        else
        begin
            pin_s1_reg <= {secondary_oscillator, low_power_rc_oscillator,
                           paired_external_input, generic_external_input};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end
    assign pin_rise = pin_s2_reg & ~pin_d_reg;

    // bus handshakes and decode
    assign aw_fire = s_axi_awvalid && awready_reg;
    assign w_fire = s_axi_wvalid && wready_reg;
    assign ar_fire = s_axi_arvalid && arready_reg;
    assign wr_do = aw_have_reg && w_have_reg &&
                   (wr_state_reg == dtc_pkg::DTC_WR_IDLE);
    assign wr_hit = (aw_addr_reg[7:5] == 3'h0) && (aw_addr_reg[1:0] == 2'h0);
    assign wr_ctrl_x = wr_do && (aw_addr_reg == `DTC_OFF_CTRL_X);
    assign wr_ctrl_y = wr_do && (aw_addr_reg == `DTC_OFF_CTRL_Y);
    assign rd_status = ar_fire && (s_axi_araddr == `DTC_OFF_STATUS);

    // write address and data are taken in either order, one at a time
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else
        begin
            aw_have_reg <= (aw_have_reg || aw_fire) && !wr_do;
            w_have_reg <= (w_have_reg || w_fire) && !wr_do;
            awready_reg <= !((aw_have_reg || aw_fire) && !wr_do);
            wready_reg <= !((w_have_reg || w_fire) && !wr_do);
            if (aw_fire)
                aw_addr_reg <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // write response; unmapped addresses answer with a slave error
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wr_state_reg <= dtc_pkg::DTC_WR_IDLE;
            bvalid_reg <= 1'b0;
            bresp_reg <= `DTC_RESP_OKAY;
        end
        else
        begin
            case (wr_state_reg)
                dtc_pkg::DTC_WR_IDLE:
                    if (wr_do)
                    begin
                        bvalid_reg <= 1'b1;
                        bresp_reg <= wr_hit ? `DTC_RESP_OKAY
                                            : `DTC_RESP_SLVERR;
                        wr_state_reg <= dtc_pkg::DTC_WR_RESP;
                    end
                dtc_pkg::DTC_WR_RESP:
                    if (s_axi_bready)
                    begin
                        bvalid_reg <= 1'b0;
                        wr_state_reg <= dtc_pkg::DTC_WR_IDLE;
                    end
                default: wr_state_reg <= dtc_pkg::DTC_WR_IDLE;
            endcase
        end
    end

    // read data mux; reserved bits are masked to zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            // [R13] reserved bits zero
            `DTC_OFF_CTRL_X: rd_mux[15:0] = ctrl_x_reg & `DTC_CTRL_X_MASK;
            `DTC_OFF_CTRL_Y: rd_mux[15:0] = ctrl_y_reg & `DTC_CTRL_Y_MASK;
            `DTC_OFF_PER_X: rd_mux[15:0] = per_x_reg;
            `DTC_OFF_PER_Y: rd_mux[15:0] = per_y_reg;
            `DTC_OFF_CNT_X: rd_mux[15:0] = cnt_x_reg;
            `DTC_OFF_CNT_Y: rd_mux[15:0] = cnt_y_reg;
            `DTC_OFF_STATUS: rd_mux[1:0] = status_reg;
            `DTC_OFF_MASK: rd_mux[1:0] = mask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read channel: one read in flight, data held until rready
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rd_state_reg <= dtc_pkg::DTC_RD_IDLE;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `DTC_RESP_OKAY;
        end
        else
        begin
            case (rd_state_reg)
                dtc_pkg::DTC_RD_IDLE:
                    if (ar_fire)
                    begin
                        arready_reg <= 1'b0;
                        rvalid_reg <= 1'b1;
                        rdata_reg <= rd_mux;
                        rresp_reg <= (s_axi_araddr[7:5] == 3'h0 &&
                                      s_axi_araddr[1:0] == 2'h0)
                                     ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
                        rd_state_reg <= dtc_pkg::DTC_RD_VALID;
                    end
                    else
                        arready_reg <= 1'b1;
                dtc_pkg::DTC_RD_VALID:
                    if (s_axi_rready)
                    begin
                        rvalid_reg <= 1'b0;
                        arready_reg <= 1'b1;
                        rd_state_reg <= dtc_pkg::DTC_RD_IDLE;
                    end
                default: rd_state_reg <= dtc_pkg::DTC_RD_IDLE;
            endcase
        end
    end

    // control, period and mask registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // [R13] control resets to zero
            ctrl_x_reg <= `DTC_CTRL_RESET;
            ctrl_y_reg <= `DTC_CTRL_RESET;
            per_x_reg <= `DTC_PER_RESET;
            per_y_reg <= `DTC_PER_RESET;
            mask_reg <= 2'h0;
        end
        else if (wr_do)
        begin
            if (wr_ctrl_x)
                ctrl_x_reg <= lane16(ctrl_x_reg, w_data_reg, w_strb_reg)
                              & `DTC_CTRL_X_MASK;
            if (wr_ctrl_y)
                ctrl_y_reg <= lane16(ctrl_y_reg, w_data_reg, w_strb_reg)
                              & `DTC_CTRL_Y_MASK;
            if (aw_addr_reg == `DTC_OFF_PER_X)
                per_x_reg <= lane16(per_x_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == `DTC_OFF_PER_Y)
                per_y_reg <= lane16(per_y_reg, w_data_reg, w_strb_reg);
            if (aw_addr_reg == `DTC_OFF_MASK && w_strb_reg[0])
                mask_reg <= w_data_reg[1:0];
        end
    end

    // [R10] cascade select
    assign cascade = ctrl_x_reg[`DTC_BIT_CASCADE];
    // [R1] [R3] first timer run gate, halted in idle when asked
    assign run_x_en = ctrl_x_reg[`DTC_BIT_RUN] &&
                      !(ctrl_x_reg[`DTC_BIT_HALT_IDLE] && idle_mode);
    // [R2] [R11] second timer runs only on its own when not cascaded
    assign run_y_en = !cascade && ctrl_y_reg[`DTC_BIT_RUN] &&
                      !(ctrl_y_reg[`DTC_BIT_HALT_IDLE] && idle_mode);

    // [R4] extended source select
    always_comb
    begin
        case (ctrl_x_reg[`DTC_BIT_EXT_HI:`DTC_BIT_EXT_LO])
            `DTC_EXT_GENERIC: ext_rise = pin_rise[0];
            `DTC_EXT_LOW_POWER_RC_OSCILLATOR: ext_rise = pin_rise[2];
            `DTC_EXT_PAIRED: ext_rise = pin_rise[1];
            default: ext_rise = pin_rise[3];
        endcase
    end

    // [R5] [R6] [R8] first timer source; gate level only on internal clock
    assign src_x = ctrl_x_reg[`DTC_BIT_CLK_SEL] ? ext_rise
                 : (!ctrl_x_reg[`DTC_BIT_GATE] || pin_s2_reg[0]);
    // [R7] [R8] second timer source: paired edges or gated internal clock
    assign src_y = ctrl_y_reg[`DTC_BIT_CLK_SEL] ? pin_rise[1]
                 : (!ctrl_y_reg[`DTC_BIT_GATE] || pin_s2_reg[1]);

    // [R12] control write while running clears the prescaler
    assign pre_clr_x = !run_x_en || (wr_ctrl_x && ctrl_x_reg[`DTC_BIT_RUN]);
    assign pre_clr_y = !run_y_en || (wr_ctrl_y && ctrl_y_reg[`DTC_BIT_RUN]);

    // [R9] prescalers, one per timer
    dtc_prescaler u_pre_x (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(pre_clr_x),
        .in_tick(src_x && run_x_en),
        .div_sel(ctrl_x_reg[`DTC_BIT_PRE_HI:`DTC_BIT_PRE_LO]),
        .out_tick(tick_x),
        .count(pre_cnt_x)
    );
    dtc_prescaler u_pre_y (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(pre_clr_y),
        .in_tick(src_y && run_y_en),
        .div_sel(ctrl_y_reg[`DTC_BIT_PRE_HI:`DTC_BIT_PRE_LO]),
        .out_tick(tick_y),
        .count(pre_cnt_y)
    );

    // [R17] [R18] period matches; cascaded compare uses both halves
    assign match_32 = cascade && tick_x &&
                      ({cnt_y_reg, cnt_x_reg} == {per_y_reg, per_x_reg});
    assign match_x = !cascade && tick_x && (cnt_x_reg == per_x_reg);
    assign match_y = tick_y && (cnt_y_reg == per_y_reg);

    // counters; a software write wins over counting in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_x_reg <= `DTC_CNT_RESET;
            cnt_y_reg <= `DTC_CNT_RESET;
        end
        else
        begin
            // [R14] [R17] low half counts from the first timer tick
            if (wr_do && aw_addr_reg == `DTC_OFF_CNT_X)
                cnt_x_reg <= lane16(cnt_x_reg, w_data_reg, w_strb_reg);
            else if (match_x || match_32)
                cnt_x_reg <= `DTC_CNT_RESET;
            else if (tick_x)
                cnt_x_reg <= cnt_x_reg + 16'h0001;
            // [R18] high half carries on low wrap when cascaded
            if (wr_do && aw_addr_reg == `DTC_OFF_CNT_Y)
                cnt_y_reg <= lane16(cnt_y_reg, w_data_reg, w_strb_reg);
            else if (match_y || match_32)
                cnt_y_reg <= `DTC_CNT_RESET;
            else if (cascade && tick_x && cnt_x_reg == 16'hFFFF)
                cnt_y_reg <= cnt_y_reg + 16'h0001;
            else if (tick_y)
                cnt_y_reg <= cnt_y_reg + 16'h0001;
        end
    end

    // mask as it stands after this edge, so irq follows a mask write at once
    assign mask_next = (wr_do && aw_addr_reg == `DTC_OFF_MASK &&
                        w_strb_reg[0]) ? w_data_reg[1:0] : mask_reg;

    // sticky events; a new event beats the read that clears it
    always_comb
    begin
        status_next = rd_status ? 2'h0 : status_reg;
        status_next[`DTC_ST_X] = status_next[`DTC_ST_X] | match_x;
        // [R15] cascaded match raises the second timer's flag
        status_next[`DTC_ST_Y] = status_next[`DTC_ST_Y] | match_y | match_32;
    end

    // status, interrupt and converter trigger
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            status_reg <= 2'h0;
            irq_reg <= 1'b0;
            adc_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_next);
            // [R16] trigger from cascaded or second timer only
            adc_reg <= match_y || match_32;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;
    assign adc_trigger = adc_reg;

    // checks
    chk_prescale_reset: assert property (@(posedge ref_clk) disable iff (rst)
        wr_ctrl_x && ctrl_x_reg[`DTC_BIT_RUN] |=> pre_cnt_x == 8'h00) // R12
        else $error("prescaler not cleared by control write");
    chk_idle_halt: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_x_reg[`DTC_BIT_HALT_IDLE] && idle_mode && !wr_do
        |=> $stable(cnt_x_reg)) // R3
        else $error("timer counted while halted in idle");
    chk_cascade_carry: assert property (@(posedge ref_clk) disable iff (rst)
        cascade && tick_x && cnt_x_reg == 16'hFFFF && !match_32 && !wr_do
        |=> cnt_y_reg == $past(cnt_y_reg) + 16'h0001) // R18
        else $error("high half missed carry");
    chk_cascade_flag: assert property (@(posedge ref_clk) disable iff (rst)
        match_32 |=> status_reg[`DTC_ST_Y] && adc_trigger) // R15
        else $error("cascaded match did not set second flag");
    chk_adc_source: assert property (@(posedge ref_clk) disable iff (rst)
        adc_trigger |-> $past(match_y) || $past(match_32)) // R16
        else $error("converter trigger from wrong timer");
    chk_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_x_reg & ~`DTC_CTRL_X_MASK) == 16'h0000 &&
        (ctrl_y_reg & ~`DTC_CTRL_Y_MASK) == 16'h0000) // R13
        else $error("reserved control bit set");
    chk_second_ignored: assert property (@(posedge ref_clk) disable iff (rst)
        cascade |-> !tick_y ##1 pre_cnt_y == 8'h00) // R11
        else $error("second timer active while cascaded");
    chk_period_wrap: assert property (@(posedge ref_clk) disable iff (rst)
        match_x && !wr_do |=> cnt_x_reg == 16'h0000 &&
        status_reg[`DTC_ST_X]) // R17
        else $error("no wrap or flag at period match");
    chk_gate_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl_x_reg[`DTC_BIT_CLK_SEL] && ctrl_x_reg[`DTC_BIT_GATE] &&
        !pin_s2_reg[0] |-> !tick_x) // R8
        else $error("gated timer ticked with gate low");
    chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
        irq == ((status_reg & mask_reg) != 2'h0)) // irq level from masked status
        else $error("interrupt level disagrees with masked status");
endmodule
`default_nettype wire

// file: tb.sv
// Purpose: self-checking bench for the cascadable dual timer
// Assumes: dtc_top register map and AXI4-Lite timing of the hand-over
// Notes:   pins are held 4 cycles so the two sync flops see every edge
`include "dtc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] cx = `DTC_OFF_CTRL_X;
    localparam logic [7:0] cy = `DTC_OFF_CTRL_Y;
    localparam logic [7:0] st = `DTC_OFF_STATUS;
    localparam logic [1:0] ok = `DTC_RESP_OKAY;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, idle = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, junk;
    logic awready, wready, bvalid, arready, rvalid, irq, trig;
    logic [1:0] bresp, rresp, jr;
    logic [3:0] pins = 4'h0; // generic, rc osc, paired, secondary
    int n_mismatch = 0, compares = 0, trigs = 0, base;
    int dv[4] = '{1, 8, 64, 256};

    dtc_top i_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .idle_mode(idle),
        .generic_external_input(pins[3]), .low_power_rc_oscillator(pins[2]),
        .paired_external_input(pins[1]), .secondary_oscillator(pins[0]),
        .irq(irq), .adc_trigger(trig));

    // free-running clock; trigger pulses are counted, not caught live
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (trig === 1'h1) trigs <= trigs + 1;

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // each channel is released at the edge where it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = ok);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever
        begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready)
            begin
                bready <= 1'h0;
                chk({30'h0, bresp}, {30'h0, er});
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever
        begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
        input logic [1:0] er = ok);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
    endtask

    // stop both, zero a count, and drop stale status
    task automatic prep(input logic [7:0] cnt, input logic [15:0] per);
        wr(cx, 32'h0); wr(cy, 32'h0);
        wr(cnt, 32'h0); wr(cnt - 8'h08, {16'h0, per});
        axi_rd(st, junk, jr);
    endtask

    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge ref_clk) pins <= m;
            cyc(4);
            pins <= 4'h0;
            cyc(4);
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang ends the run as a failure
    initial
    begin
        cyc(30000);
        n_mismatch++;
        print_verdict;
    end

    initial
    begin
        cyc(16);
        rst <= 1'h0;
        rdc(cx, 32'h0);
        rdc(cy, 32'h0);
        wr(cx, 32'hFFFF);
        rdc(cx, `DTC_CTRL_X_MASK);
        wr(cy, 32'hFFFF);
        rdc(cy, `DTC_CTRL_Y_MASK);
        wr(8'h20, 32'h1, `DTC_RESP_SLVERR);
        rdc(8'h20, 32'h0, `DTC_RESP_SLVERR);
        wr(`DTC_OFF_MASK, 32'h1);
        $display("test registers done");
        // period 3 matches after four prescaled ticks
        for (int c = 1; c < 4; c++)
        begin
            prep(`DTC_OFF_CNT_X, 16'h3);
            wr(cx, 32'h8000 | (c << 4));
            cyc(2 * dv[c]);
            rdc(st, 32'h0);
            cyc(3 * dv[c]);
            wr(cx, 32'h0);
            chk(irq, 1'h1);
            rdc(st, 32'h1);
            cyc(2);
            chk(irq, 1'h0);
        end
        chk(trigs, 0);
        $display("test prescale done");
        // every extended source code, wrong pins first; gate is ignored
        for (int c = 0; c < 4; c++)
        begin
            prep(`DTC_OFF_CNT_X, 16'h3);
            wr(cx, 32'h8042 | (c << 8));
            pulse(~(4'h1 << c), 4);
            rdc(st, 32'h0);
            pulse(4'h1 << c, 4);
            wr(cx, 32'h0);
            rdc(st, 32'h1);
        end
        prep(`DTC_OFF_CNT_Y, 16'h3);
        wr(cy, 32'h8002);
        pulse(4'h1, 6);
        rdc(st, 32'h0);
        pulse(4'h2, 4);
        rdc(st, 32'h2);
        $display("test sources done");
        // gated accumulation on the internal clock
        prep(`DTC_OFF_CNT_X, 16'h3);
        wr(cx, 32'h8040);
        cyc(30);
        rdc(st, 32'h0);
        pins <= 4'h8;
        cyc(20);
        wr(cx, 32'h0);
        pins <= 4'h0;
        rdc(st, 32'h1);
        $display("test gate done");
        // halt in idle on the second timer alone
        prep(`DTC_OFF_CNT_Y, 16'h3);
        idle <= 1'h1;
        base = trigs;
        wr(cy, 32'hA000);
        cyc(30);
        rdc(st, 32'h0);
        idle <= 1'h0;
        cyc(10);
        wr(cy, 32'h0);
        rdc(st, 32'h2);
        chk(trigs > base, 1'h1);
        $display("test idle done");
        // low half carries into the high half; second control ignored
        prep(`DTC_OFF_CNT_Y, 16'h1);
        wr(`DTC_OFF_PER_X, 32'h4);
        wr(`DTC_OFF_CNT_X, 32'hFFF0);
        // second control asks to run and to halt in idle; both must be moot
        idle <= 1'h1;
        wr(cy, 32'hA030);
        base = trigs;
        wr(cx, 32'h8008);
        cyc(40);
        wr(cx, 32'h0);
        rdc(st, 32'h2);
        rdc(`DTC_OFF_CNT_Y, 32'h0);
        chk(trigs - base, 1);
        idle <= 1'h0;
        $display("test cascade done");
        print_verdict;
    end
endmodule
`default_nettype wire
